//--- design/pulse_pkg.sv
// Purpose: Shared constants for the dual one-shot pulse generator
// Assumes: Byte-wide register port, 25 MHz system clock
// Notes:   Offsets are byte addresses on the plain register port
package pulse_pkg;

  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  localparam int          PRESCALE_W      = 3;
  localparam int          DIV_W           = 7;

  localparam logic [7:0]  OFS_CMP_A_TRIM  = 8'h1c;
  localparam logic [7:0]  OFS_CTRL_A      = 8'h20;
  localparam logic [7:0]  OFS_PRELOAD_A   = 8'h21;
  localparam logic [7:0]  OFS_CTRL_B      = 8'h22;
  localparam logic [7:0]  OFS_PRELOAD_B   = 8'h23;

  localparam int          BIT_RUN         = 7;
  localparam int          BIT_RESTART_EN  = 6;
  localparam int          BIT_STOP_EN     = 5;
  localparam int          BIT_PSC_LO      = 2;
  localparam int          BIT_CMP_B_EN    = 1;
  localparam int          BIT_SWAP        = 0;
  localparam int          BIT_CMP_A_EN    = 0;

  localparam int          BIT_REF_SEL     = 4;
  localparam int          BIT_CAL_MODE    = 5;
  localparam int          BIT_CMP_RESULT  = 6;

  localparam logic [3:0]  TRIM_RESET      = 4'h8;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam logic [7:0]  PRELOAD_RESET   = 8'h00;
  localparam logic [7:0]  COUNT_LAST      = 8'hff;

endpackage

//--- design/one_shot_channel.sv
// Purpose: One pulse channel: prescaler, 8-bit up-counter, run state
// Assumes: start and stop are one-cycle pulses on the system clock
// Notes:   Stop wins over start in the same cycle
`timescale 1ns/10ps
module one_shot_channel
  import pulse_pkg::*;
#(
  parameter bit SYNC_START = 1'b1
) (
  input  wire logic                  clock,
  input  wire logic                  rst_b,
  input  wire logic                  start,
  input  wire logic                  stop,
  input  wire logic [PRESCALE_W-1:0] prescale,
  input  wire logic [7:0]            preload,
  output logic                       running,
  output logic                       overflow
);

  typedef struct packed {
    logic             run;
    logic [DIV_W-1:0] div;
    logic [7:0]       count;
  } chan_s;

  chan_s st_q;
  chan_s st_d;
  logic  tick;

  // Selected prescaled tick, all low bits of divider set
  always_comb begin
    tick = 1'b1;
    for (int i = 0; i < DIV_W; i++) begin
      if (i < int'(prescale) && !st_q.div[i]) begin
        tick = 1'b0;
      end
    end
  end

  always_comb begin
    st_d     = st_q;
    overflow = 1'b0;
    if (st_q.run) begin
      st_d.div = st_q.div + 1'b1;
      if (tick) begin
        if (st_q.count == COUNT_LAST) begin
          overflow = 1'b1;
        end else begin
          st_d.count = st_q.count + 1'b1;
        end
      end
    end
    if (stop || overflow) begin
      st_d.run   = 1'b0;
      st_d.div   = '0;
      st_d.count = preload;
    end else if (start && !st_q.run) begin
      st_d.run   = 1'b1;
      st_d.div   = '0;
      st_d.count = preload;
      if (!SYNC_START) begin
        st_d.div = 7'h01;
        if (prescale == 3'h0) begin
          st_d.count = preload + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign running = st_q.run;

endmodule

//--- design/dual_one_shot_pulse_generator.sv
// Purpose: Two one-shot pulse channels with trigger routing and trim register
// Assumes: Byte register port; triggers and pins are asynchronous
// Notes:   Read data valid one cycle after the read strobe
// Operation
// - Prescale A codes divide by 1 to 128
// - Prescale B uses the same divide encoding
// - Stop enable A stops on shared stop fall
// - Restart enable A starts on comparator B fall
// - Without stop enable, only software or overflow
// - Swap bit routes stop and restart sources
// - Run A write starts, stops; auto clears
// - Run B write starts, stops; auto clears
// - Retrigger while counting is ignored
// - Run bit reads back output activity
// - Polarity option selects active high or low
// - Sync option delays start to clock
// - Channel B control register field layout
// - Stop enable B stops on ext irq A fall
// - Restart enable B starts on shared restart fall
// - Start loads counter from preload
// - Overflow alone stops the channel
// - Port pins read comparator output when enabled
// - Trim register fields and reset values
// - Stop clears prescaler, reloads, clears run
// - Counter overflows at FF and reloads preload
`timescale 1ns/10ps
module dual_one_shot_pulse_generator
  import pulse_pkg::*;
#(
  parameter bit POLARITY_A   = 1'b0,
  parameter bit POLARITY_B   = 1'b0,
  parameter bit SYNC_START_A = 1'b1,
  parameter bit SYNC_START_B = 1'b1
) (
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  input  wire logic              cmp_a_out,
  input  wire logic              cmp_b_out,
  input  wire logic              ext_irq_a,
  input  wire logic              ext_irq_b,
  input  wire logic              port_c_bit2_pad,
  input  wire logic              port_c_bit3_pad,
  input  wire logic              port_c_bit2_dir_in,
  input  wire logic              port_c_bit3_dir_in,
  output logic                   pulse_a,
  output logic                   pulse_b,
  output logic                   port_c_bit2_in,
  output logic                   port_c_bit3_in,
  output logic                   cmp_a_en,
  output logic                   cmp_b_en,
  output logic      [3:0]        offset_trim,
  output logic                   offset_ref_sel,
  output logic                   offset_cal_mode
);

  // Sources: cmp_a, cmp_b, irq_a, irq_b, pad2, pad3
  localparam int NSRC = 6;

  typedef struct packed {
    logic [NSRC-1:0]   s1;
    logic [NSRC-1:0]   s2;
    logic [NSRC-1:0]   s3;
    logic [NSRC-1:0]   src_f;
    logic [7:0]        ctrl_a;
    logic [7:0]        ctrl_b;
    logic [7:0]        preload_a;
    logic [7:0]        preload_b;
    logic [3:0]        trim;
    logic              ref_sel;
    logic              cal_mode;
    logic              stop_prev;
    logic              rest_prev;
    logic              cmpb_prev;
    logic              irqa_prev;
    logic              start_a;
    logic              stop_a;
    logic              start_b;
    logic              stop_b;
    logic              out_a;
    logic              out_b;
    logic              pin2;
    logic              pin3;
    logic [DATA_W-1:0] rdata;
  } top_s;

  top_s st_q;
  top_s st_d;

  logic run_a;
  logic run_b;
  logic ovf_a;
  logic ovf_b;

  // Three-stage capture: changes accepted when stage 2 and 3 agree
  function automatic logic filt(input logic prev, input logic b2, input logic b3);
    filt = (b2 == b3) ? b3 : prev;
  endfunction

  function automatic logic fell(input logic prev, input logic now);
    fell = prev && !now;
  endfunction

  always_comb begin
    logic cmp_a_f;
    logic cmp_b_f;
    logic irq_a_f;
    logic irq_b_f;
    logic stop_src;
    logic rest_src;
    logic swap;
    logic sw_start_a;
    logic sw_stop_a;
    logic sw_start_b;
    logic sw_stop_b;
    cmp_a_f    = 1'b0;
    cmp_b_f    = 1'b0;
    irq_a_f    = 1'b0;
    irq_b_f    = 1'b0;
    stop_src   = 1'b0;
    rest_src   = 1'b0;
    swap       = 1'b0;
    sw_start_a = 1'b0;
    sw_stop_a  = 1'b0;
    sw_start_b = 1'b0;
    sw_stop_b  = 1'b0;
    st_d       = st_q;

    st_d.s1 = {port_c_bit3_pad, port_c_bit2_pad, ext_irq_b, ext_irq_a, cmp_b_out, cmp_a_out};
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;

    // Filtered level per source, held while stages 2 and 3 disagree
    for (int i = 0; i < NSRC; i++) begin
      st_d.src_f[i] = filt(st_q.src_f[i], st_q.s2[i], st_q.s3[i]);
    end
    cmp_a_f = st_d.src_f[0];
    cmp_b_f = st_d.src_f[1];
    irq_a_f = st_d.src_f[2];
    irq_b_f = st_d.src_f[3];

    // Trigger routing
    swap     = st_q.ctrl_b[BIT_SWAP];
    stop_src = swap ? cmp_a_f : irq_b_f;
    rest_src = swap ? irq_b_f : cmp_a_f;
    st_d.stop_prev = stop_src;
    st_d.rest_prev = rest_src;
    st_d.cmpb_prev = cmp_b_f;
    st_d.irqa_prev = irq_a_f;

    // Software writes
    if (wr && addr == OFS_CTRL_A) begin
      sw_start_a = wdata[BIT_RUN];
      sw_stop_a  = !wdata[BIT_RUN];
      st_d.ctrl_a = wdata;
    end
    if (wr && addr == OFS_CTRL_B) begin
      sw_start_b = wdata[BIT_RUN];
      sw_stop_b  = !wdata[BIT_RUN];
      st_d.ctrl_b = {wdata[7:2], 1'b0, wdata[0]};
    end
    if (wr && addr == OFS_PRELOAD_A) begin
      st_d.preload_a = wdata;
    end
    if (wr && addr == OFS_PRELOAD_B) begin
      st_d.preload_b = wdata;
    end
    if (wr && addr == OFS_CMP_A_TRIM) begin
      st_d.trim     = wdata[3:0];
      st_d.ref_sel  = wdata[BIT_REF_SEL];
      st_d.cal_mode = wdata[BIT_CAL_MODE];
    end

    // Start and stop events, one cycle each
    st_d.stop_a  = sw_stop_a
                 || (st_q.ctrl_a[BIT_STOP_EN] && fell(st_q.stop_prev, stop_src));
    st_d.start_a = sw_start_a
                 || (st_q.ctrl_a[BIT_RESTART_EN] && fell(st_q.cmpb_prev, cmp_b_f));
    st_d.stop_b  = sw_stop_b
                 || (st_q.ctrl_b[BIT_STOP_EN] && fell(st_q.irqa_prev, irq_a_f));
    st_d.start_b = sw_start_b
                 || (st_q.ctrl_b[BIT_RESTART_EN] && fell(st_q.rest_prev, rest_src));

    // Run bits track channel activity
    st_d.ctrl_a[BIT_RUN] = run_a || (st_q.start_a && !st_q.stop_a);
    st_d.ctrl_b[BIT_RUN] = run_b || (st_q.start_b && !st_q.stop_b);
    if (ovf_a || st_q.stop_a) begin
      st_d.ctrl_a[BIT_RUN] = 1'b0;
    end
    if (ovf_b || st_q.stop_b) begin
      st_d.ctrl_b[BIT_RUN] = 1'b0;
    end
    if (sw_start_a) begin
      st_d.ctrl_a[BIT_RUN] = 1'b1;
    end
    if (sw_start_b) begin
      st_d.ctrl_b[BIT_RUN] = 1'b1;
    end

    // Outputs with polarity option
    st_d.out_a = run_a ^ POLARITY_A;
    st_d.out_b = run_b ^ POLARITY_B;
    // Overflow lets the last counted cycle finish; a stop cuts at once
    if (st_q.stop_a) begin
      st_d.out_a = POLARITY_A;
    end
    if (st_q.stop_b) begin
      st_d.out_b = POLARITY_B;
    end

    // Port pins show comparator output when enabled and input
    st_d.pin2 = (st_q.ctrl_a[BIT_CMP_A_EN] && port_c_bit2_dir_in) ? cmp_a_f : st_d.src_f[4];
    st_d.pin3 = (st_q.ctrl_a[BIT_CMP_B_EN] && port_c_bit3_dir_in) ? cmp_b_f : st_d.src_f[5];

    // Read port
    st_d.rdata = '0;
    if (rd) begin
      unique case (addr)
        OFS_CTRL_A:     st_d.rdata = st_q.ctrl_a;
        OFS_CTRL_B:     st_d.rdata = st_q.ctrl_b;
        OFS_PRELOAD_A:  st_d.rdata = st_q.preload_a;
        OFS_PRELOAD_B:  st_d.rdata = st_q.preload_b;
        OFS_CMP_A_TRIM: st_d.rdata = {1'b0, cmp_a_f, st_q.cal_mode, st_q.ref_sel, st_q.trim};
        default:        st_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_q           <= '0;
      st_q.trim      <= TRIM_RESET;
      st_q.ctrl_a    <= CTRL_RESET;
      st_q.ctrl_b    <= CTRL_RESET;
      st_q.preload_a <= PRELOAD_RESET;
      st_q.preload_b <= PRELOAD_RESET;
      st_q.out_a     <= POLARITY_A;
      st_q.out_b     <= POLARITY_B;
    end else begin
      st_q <= st_d;
    end
  end

  one_shot_channel #(
    .SYNC_START (SYNC_START_A)
  ) u_chan_a (
    .clock    (clock),
    .rst_b    (rst_b),
    .start    (st_q.start_a),
    .stop     (st_q.stop_a),
    .prescale (st_q.ctrl_a[BIT_PSC_LO +: PRESCALE_W]),
    .preload  (st_q.preload_a),
    .running  (run_a),
    .overflow (ovf_a)
  );

  one_shot_channel #(
    .SYNC_START (SYNC_START_B)
  ) u_chan_b (
    .clock    (clock),
    .rst_b    (rst_b),
    .start    (st_q.start_b),
    .stop     (st_q.stop_b),
    .prescale (st_q.ctrl_b[BIT_PSC_LO +: PRESCALE_W]),
    .preload  (st_q.preload_b),
    .running  (run_b),
    .overflow (ovf_b)
  );

  assign rdata           = st_q.rdata;
  assign pulse_a         = st_q.out_a;
  assign pulse_b         = st_q.out_b;
  assign port_c_bit2_in  = st_q.pin2;
  assign port_c_bit3_in  = st_q.pin3;
  assign cmp_a_en        = st_q.ctrl_a[BIT_CMP_A_EN];
  assign cmp_b_en        = st_q.ctrl_a[BIT_CMP_B_EN];
  assign offset_trim     = st_q.trim;
  assign offset_ref_sel  = st_q.ref_sel;
  assign offset_cal_mode = st_q.cal_mode;

endmodule

//--- verif/pulse_chk.sv
// Purpose: Port checks for the pulse generator
// Assumes: Default parameters, active-high pulses
// Notes:   Bound to the top module
`timescale 1ns/10ps
module pulse_chk
  import pulse_pkg::*;
(
  input wire logic              clock,
  input wire logic              rst_b,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic              cmp_a_out,
  input wire logic              port_c_bit2_dir_in,
  input wire logic              pulse_a,
  input wire logic              pulse_b,
  input wire logic              port_c_bit2_in,
  input wire logic              cmp_a_en,
  input wire logic [3:0]        offset_trim,
  input wire logic              offset_cal_mode
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence sw_start(a, p);
    wr && addr == a && wdata[7] && !wdata[5] && !p;
  endsequence
  sequence sw_stop(a, p);
    wr && addr == a && !wdata[7] && p;
  endsequence
  AST_START_A: assert property (sw_start(OFS_CTRL_A, pulse_a) |-> ##3 pulse_a)
    else $error("pulse a did not start");
  AST_START_B: assert property (sw_start(OFS_CTRL_B, pulse_b) |-> ##3 pulse_b)
    else $error("pulse b did not start");
  AST_STOP_A: assert property (sw_stop(OFS_CTRL_A, pulse_a) |-> ##[1:4] !pulse_a)
    else $error("pulse a did not stop");
  AST_STOP_B: assert property (sw_stop(OFS_CTRL_B, pulse_b) |-> ##[1:4] !pulse_b)
    else $error("pulse b did not stop");
  AST_CTRL_B_GAP: assert property (rd && addr == OFS_CTRL_B |=> !rdata[1])
    else $error("unused control bit read high");
  AST_TRIM_READ: assert property (rd && addr == OFS_CMP_A_TRIM |=>
    !rdata[7] && rdata[3:0] == offset_trim) else $error("trim read wrong");
  AST_TRIM_WRITE: assert property (wr && addr == OFS_CMP_A_TRIM |=>
    offset_trim == $past(wdata[3:0]) && offset_cal_mode == $past(wdata[5]))
    else $error("trim write lost");
  AST_TRIM_RESET: assert property ($rose(rst_b) |-> offset_trim == 4'h8)
    else $error("trim reset value wrong");
  AST_PIN_CMP: assert property ((cmp_a_en && port_c_bit2_dir_in && $stable(cmp_a_out))[*6]
    |-> port_c_bit2_in == cmp_a_out) else $error("pin does not show comparator");
endmodule
bind dual_one_shot_pulse_generator pulse_chk u_pulse_chk (.clock(clock), .rst_b(rst_b),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cmp_a_out(cmp_a_out),
  .port_c_bit2_dir_in(port_c_bit2_dir_in), .pulse_a(pulse_a), .pulse_b(pulse_b),
  .port_c_bit2_in(port_c_bit2_in), .cmp_a_en(cmp_a_en), .offset_trim(offset_trim),
  .offset_cal_mode(offset_cal_mode));

//--- verif/trig_src.sv
// Purpose: Far-side trigger sources
// Assumes: Lines idle high
// Notes:   A request pulls its line low for four cycles
`timescale 1ns/10ps
module trig_src (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic [3:0] fall_req,
  output logic      [3:0] lines
);
  logic [2:0] cnt_q [4];
  always_ff @(posedge clock or negedge rst_b) begin
    for (int i = 0; i < 4; i++) begin
      if (!rst_b) begin
        cnt_q[i] <= 3'd0;
      end else if (fall_req[i]) begin
        cnt_q[i] <= 3'd4;
      end else if (cnt_q[i] != 3'd0) begin
        cnt_q[i] <= cnt_q[i] - 3'd1;
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lines[i] = (cnt_q[i] == 3'd0);
    end
  end
endmodule

//--- verif/tb.sv
// Purpose: Self-checking bench for the pulse generator
// Assumes: Default parameters
// Notes:   Trigger lines: 0 cmp a, 1 cmp b, 2 irq a, 3 irq b
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb
  import pulse_pkg::*;
;
  logic        clock = 0, rst_b = 0, wr = 0, rd = 0, pa, pb, pin2, pin3, ena, enb, rsel, cal;
  logic [7:0]  addr = 0, wdata = 0, rdata;
  logic [3:0]  req = 0, trig, trim;
  logic [31:0] seed = 32'h5d7d_e87e;
  int          fails = 0, total_checks = 0, cyc = 0;
  logic [31:0] tab [11] = '{32'h0000_0200, 32'h4000_0202, 32'h8000_0802, 32'ha000_0102,
    32'ha000_0800, 32'ha001_0100, 32'h0040_0101, 32'h00a0_0400, 32'h0041_0801,
    32'h0081_0401, 32'h0040_0800};
  trig_src u_trig_src (.clock(clock), .rst_b(rst_b), .fall_req(req), .lines(trig));
  dual_one_shot_pulse_generator u_dual_one_shot_pulse_generator (.clock(clock),
    .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .cmp_a_out(trig[0]), .cmp_b_out(trig[1]), .ext_irq_a(trig[2]), .ext_irq_b(trig[3]),
    .port_c_bit2_pad(seed[4]), .port_c_bit3_pad(seed[5]), .port_c_bit2_dir_in(1'b1),
    .port_c_bit3_dir_in(1'b1), .pulse_a(pa), .pulse_b(pb), .port_c_bit2_in(pin2),
    .port_c_bit3_in(pin3), .cmp_a_en(ena), .cmp_b_en(enb), .offset_trim(trim),
    .offset_ref_sel(rsel), .offset_cal_mode(cal));
  always #20 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      report_and_stop();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    d = rdata;
  endtask
  task automatic width(input logic [7:0] c, input logic [7:0] pre, input logic [2:0] code,
                       input bit re);
    int w;
    logic [7:0] r;
    w = 0;
    wreg(c + 8'h01, pre);
    wreg(c, {3'b100, code, 2'b00});
    fork
      for (int i = 0; i < ((257 - pre) << code) + 20; i++) begin
        @(negedge clock);
        w += (c == OFS_CTRL_A) ? pa : pb;
      end
      if (re) begin
        repeat (50) @(posedge clock);
        wreg(c, 8'h80);
        rreg(c, r);
        `CHK(r[7], 1'b1)
      end
    join
    `CHK(w, (256 - int'(pre)) << code)
    rreg(c, r);
    `CHK(r[7], 1'b0)
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    logic [7:0] r;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    rreg(OFS_CTRL_B, r);
    `CHK(r, CTRL_RESET)
    rreg(OFS_CMP_A_TRIM, r);
    `CHK(r, {4'h4, TRIM_RESET})
    rreg(8'h30, r);
    `CHK(r, 8'h00)
    wreg(OFS_CTRL_B, 8'h7e);
    rreg(OFS_CTRL_B, r);
    `CHK(r, 8'h7c)
    wreg(OFS_CMP_A_TRIM, 8'hba);
    rreg(OFS_CMP_A_TRIM, r);
    `CHK({r, trim, rsel, cal}, {8'h7a, 4'ha, 2'b11})
    // Calibration pass: step the trim in cal mode, then return to compare mode
    for (int t = 0; t < 16; t += 5) begin
      wreg(OFS_CMP_A_TRIM, 8'h30 | 8'(t));
    end
    wreg(OFS_CMP_A_TRIM, 8'h18);
    @(negedge clock);
    `CHK({trim, rsel, cal}, {4'h8, 2'b10})
    $display("register test done");
    for (int k = 0; k < 16; k++) begin
      seed = lfsr(seed);
      width(k[0] ? OFS_CTRL_B : OFS_CTRL_A, 8'hf0 | seed[3:0], k[3:1], 1'b0);
    end
    width(OFS_CTRL_A, 8'h00, 3'd0, 1'b1);
    width(OFS_CTRL_B, 8'hff, 3'd3, 1'b0);
    $display("width test done");
    wreg(OFS_CTRL_A, 8'h80);
    repeat (20) @(posedge clock);
    wreg(OFS_CTRL_A, 8'h00);
    repeat (4) @(negedge clock);
    `CHK(pa, 1'b0)
    width(OFS_CTRL_A, 8'h80, 3'd0, 1'b0);
    $display("stop test done");
    wreg(OFS_PRELOAD_A, 8'h00);
    wreg(OFS_PRELOAD_B, 8'h00);
    foreach (tab[i]) begin
      wreg(OFS_CTRL_B, tab[i][23:16] & 8'h81);
      wreg(OFS_CTRL_B, tab[i][23:16]);
      wreg(OFS_CTRL_A, tab[i][31:24]);
      repeat (4) @(posedge clock);
      req <= tab[i][11:8];
      @(posedge clock);
      req <= 4'h0;
      repeat (12) @(negedge clock);
      `CHK({pa, pb}, tab[i][1:0])
    end
    $display("trigger test done");
    wreg(OFS_CTRL_A, 8'h03);
    repeat (8) @(negedge clock);
    `CHK({ena, enb, pin2, pin3}, {2'b11, trig[0], trig[1]})
    $display("pin test done");
    report_and_stop();
  end
endmodule
